// >>> common/pin_pull_pkg.sv
// constants for the pin pull and keeper control register block
package pin_pull_pkg;
  localparam int          apb_addr_w         = 16;
  localparam logic [15:0] pull_ctrl_offset   = 16'h8800;
  localparam logic [15:0] pull_ctrl_reset    = 16'h0000;
  localparam int          ctrl_bits          = 8;
  localparam int          reg_width          = 16;
  localparam int          bit_debug_pins     = 7;
  localparam int          bit_test_port      = 6;
  localparam int          bit_watchdog_pin   = 5;
  localparam int          bit_host_ctrl      = 4;
  localparam int          bit_host_data      = 3;
  localparam int          bit_ext_mem_ctrl   = 2;
  localparam int          bit_ext_mem_data   = 1;
  localparam int          bit_ext_mem_addr   = 0;
  localparam int          debug_pin_count    = 2;
  localparam int          test_pull_count    = 3;
  localparam int          host_ctrl_count    = 10;
  localparam int          host_ctrl_pd_index = 1;
  localparam int          host_data_count    = 8;
  localparam int          ext_ctrl_count     = 16;
  localparam logic [15:0] ext_ctrl_pullups   = 16'h4008;
  localparam int          ext_data_count     = 32;
  localparam int          ext_addr_count     = 20;
endpackage

// >>> rtl/pull_group_driver.sv
// fans one control bit out to the active-low enables of a pin group
`timescale 1ns/100ps
module pull_group_driver
  import pin_pull_pkg::*;
#(
  parameter int count = 8
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             off_bit,
  output logic [count-1:0]      cell_en_n
);
  typedef struct packed {
    logic [count-1:0] en_n;
  } drv_state_t;

  drv_state_t state;
  drv_state_t next_state;

  // each cell gets its own flop so placement can sit near the pad ring
  always_comb begin
    next_state = state;
    for (int i = 0; i < count; i++) begin
      next_state.en_n[i] = off_bit;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cell_en_n = state.en_n;
endmodule

// >>> rtl/pin_pull_keeper_control.sv
// apb register bank steering pin pulls and bus keepers
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
module pin_pull_keeper_control
  import pin_pull_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [apb_addr_w-1:0]      paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic [debug_pin_count-1:0]      debug_pull_en_n,
  output logic [test_pull_count-1:0]      test_pullup_en_n,
  output logic                            test_reset_pulldown_en_n,
  output logic                            watchdog_pull_en_n,
  output logic [host_ctrl_count-1:0]      host_ctrl_pull_en_n,
  output logic [host_data_count-1:0]      host_data_keeper_en_n,
  output logic [ext_ctrl_count-1:0]       ext_ctrl_keeper_en_n,
  output logic [ext_data_count-1:0]       ext_data_keeper_en_n,
  output logic [ext_addr_count-1:0]       ext_addr_keeper_en_n
);
  typedef struct packed {
    logic [ctrl_bits-1:0] ctrl;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  function automatic logic hits_ctrl(input logic [apb_addr_w-1:0] a);
    hits_ctrl = (a == pull_ctrl_offset);
  endfunction

  logic access;
  logic wr_hit;

  // zero wait states: every access completes in its first access cycle
  assign access = psel && penable;
  assign wr_hit = access && pwrite && hits_ctrl(paddr) && pstrb[0];

  always_comb begin
    next_state = state;
    if (wr_hit) begin
      next_state.ctrl = pwdata[ctrl_bits-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{ctrl: pull_ctrl_reset[ctrl_bits-1:0]};
    end else begin
      state <= next_state;
    end
  end

  // read data is combinational from the stored word so it is valid in the access phase
  assign prdata  = (access && !pwrite && hits_ctrl(paddr)) ?
                   {24'h000000, state.ctrl} : 32'h00000000;
  assign pready  = 1'b1;
  assign pslverr = access && !hits_ctrl(paddr);

  logic [debug_pin_count-1:0] dbg_en_n;
  logic [test_pull_count:0]   test_en_n;
  logic [0:0]                 wdt_en_n;

  pull_group_driver #(.count(debug_pin_count)) u_debug (
    .core_clk (core_clk),
    .resetn   (resetn),
    .off_bit  (state.ctrl[bit_debug_pins]),
    .cell_en_n(dbg_en_n)
  );
  pull_group_driver #(.count(test_pull_count + 1)) u_test (
    .core_clk (core_clk),
    .resetn   (resetn),
    .off_bit  (state.ctrl[bit_test_port]),
    .cell_en_n(test_en_n)
  );
  pull_group_driver #(.count(1)) u_wdt (
    .core_clk (core_clk),
    .resetn   (resetn),
    .off_bit  (state.ctrl[bit_watchdog_pin]),
    .cell_en_n(wdt_en_n)
  );
  // pulldown on line one shares the enable with the pullups
  pull_group_driver #(.count(host_ctrl_count)) u_hctl (
    .core_clk (core_clk),
    .resetn   (resetn),
    .off_bit  (state.ctrl[bit_host_ctrl]),
    .cell_en_n(host_ctrl_pull_en_n)
  );
  pull_group_driver #(.count(host_data_count)) u_hdat (
    .core_clk (core_clk),
    .resetn   (resetn),
    .off_bit  (state.ctrl[bit_host_data]),
    .cell_en_n(host_data_keeper_en_n)
  );
  pull_group_driver #(.count(ext_ctrl_count)) u_ectl (
    .core_clk (core_clk),
    .resetn   (resetn),
    .off_bit  (state.ctrl[bit_ext_mem_ctrl]),
    .cell_en_n(ext_ctrl_keeper_en_n)
  );
  pull_group_driver #(.count(ext_data_count)) u_edat (
    .core_clk (core_clk),
    .resetn   (resetn),
    .off_bit  (state.ctrl[bit_ext_mem_data]),
    .cell_en_n(ext_data_keeper_en_n)
  );
  pull_group_driver #(.count(ext_addr_count)) u_eadr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .off_bit  (state.ctrl[bit_ext_mem_addr]),
    .cell_en_n(ext_addr_keeper_en_n)
  );

  assign debug_pull_en_n          = dbg_en_n;
  assign test_pullup_en_n         = test_en_n[test_pull_count-1:0];
  assign test_reset_pulldown_en_n = test_en_n[test_pull_count];
  assign watchdog_pull_en_n       = wdt_en_n[0];

  sequence write_ctrl_s;
    wr_hit;
  endsequence

  property enable_follows_p(int b, logic en);
    @(posedge core_clk) disable iff (!resetn)
      write_ctrl_s |-> ##2 en == $past(pwdata[b], 2);
  endproperty

  a_debug_follows_write: assert property (enable_follows_p(7, debug_pull_en_n[0]))
    else $error("debug pull enable did not follow write");
  a_test_follows_write: assert property (enable_follows_p(6, test_reset_pulldown_en_n))
    else $error("test pulldown enable did not follow write");
  a_wdt_follows_write: assert property (enable_follows_p(5, watchdog_pull_en_n))
    else $error("watchdog pull enable did not follow write");
  a_hctl_follows_write: assert property (enable_follows_p(4, host_ctrl_pull_en_n[1]))
    else $error("host control enable did not follow write");
  a_hdat_follows_write: assert property (enable_follows_p(3, host_data_keeper_en_n[7]))
    else $error("host data keeper enable did not follow write");
  a_ectl_follows_write: assert property (enable_follows_p(2, ext_ctrl_keeper_en_n[14]))
    else $error("memory control keeper enable did not follow write");
  a_edat_follows_write: assert property (enable_follows_p(1, ext_data_keeper_en_n[31]))
    else $error("memory data keeper enable did not follow write");
  a_eadr_follows_write: assert property (enable_follows_p(0, ext_addr_keeper_en_n[19]))
    else $error("memory address keeper enable did not follow write");
  a_group_uniform: assert property (@(posedge core_clk) disable iff (!resetn)
      ext_data_keeper_en_n == {ext_data_count{ext_data_keeper_en_n[0]}})
    else $error("data keeper group not uniform");
  a_read_upper_zero: assert property (@(posedge core_clk) disable iff (!resetn)
      prdata[31:ctrl_bits] == 24'h000000)
    else $error("reserved bits read nonzero");
  a_enable_stable: assert property (@(posedge core_clk) disable iff (!resetn)
      !$past(wr_hit) && !$past(wr_hit, 2) |-> $stable(watchdog_pull_en_n))
    else $error("enable changed without a write");

  // transfer kinds, kept apart so each check reads as one condition
  sequence rd_ctrl_s;
    access && !pwrite && hits_ctrl(paddr);
  endsequence

  sequence rd_other_s;
    access && !pwrite && !hits_ctrl(paddr);
  endsequence

  sequence wr_other_s;
    access && pwrite && !hits_ctrl(paddr);
  endsequence

  sequence wr_masked_s;
    access && pwrite && hits_ctrl(paddr) && !pstrb[0];
  endsequence

  // no write in the two edges before: register and pins agree again
  sequence quiet_s;
    !$past(wr_hit) && !$past(wr_hit, 2);
  endsequence

  property read_matches_p(int b, logic en);
    @(posedge core_clk) disable iff (!resetn)
      rd_ctrl_s and quiet_s |-> prdata[b] == en;
  endproperty

  a_debug_read_pins: assert property (read_matches_p(7, debug_pull_en_n[1]))
    else $error("debug pins disagree with readback");
  a_test_read_pins: assert property (read_matches_p(6, test_pullup_en_n[0]))
    else $error("test pins disagree with readback");
  a_wdt_read_pins: assert property (read_matches_p(5, watchdog_pull_en_n))
    else $error("watchdog pin disagrees with readback");
  a_hctl_read_pins: assert property (read_matches_p(4, host_ctrl_pull_en_n[0]))
    else $error("host control pins disagree with readback");
  a_hdat_read_pins: assert property (read_matches_p(3, host_data_keeper_en_n[0]))
    else $error("host data pins disagree with readback");
  a_ectl_read_pins: assert property (read_matches_p(2, ext_ctrl_keeper_en_n[0]))
    else $error("memory control pins disagree with readback");
  a_edat_read_pins: assert property (read_matches_p(1, ext_data_keeper_en_n[0]))
    else $error("memory data pins disagree with readback");
  a_eadr_read_pins: assert property (read_matches_p(0, ext_addr_keeper_en_n[0]))
    else $error("memory address pins disagree with readback");

  // pins must hold for one edge after the access: two flop stages
  property lag_p(logic en);
    @(posedge core_clk) disable iff (!resetn)
      write_ctrl_s ##0 !$past(wr_hit) |=> $stable(en);
  endproperty

  a_debug_lags_write: assert property (lag_p(debug_pull_en_n[0]))
    else $error("debug enable moved too early");
  a_test_lags_write: assert property (lag_p(test_reset_pulldown_en_n))
    else $error("test enable moved too early");
  a_wdt_lags_write: assert property (lag_p(watchdog_pull_en_n))
    else $error("watchdog enable moved too early");
  a_hctl_lags_write: assert property (lag_p(host_ctrl_pull_en_n[0]))
    else $error("host control enable moved too early");
  a_hdat_lags_write: assert property (lag_p(host_data_keeper_en_n[0]))
    else $error("host data enable moved too early");
  a_ectl_lags_write: assert property (lag_p(ext_ctrl_keeper_en_n[0]))
    else $error("memory control enable moved too early");
  a_edat_lags_write: assert property (lag_p(ext_data_keeper_en_n[0]))
    else $error("memory data enable moved too early");
  a_eadr_lags_write: assert property (lag_p(ext_addr_keeper_en_n[0]))
    else $error("memory address enable moved too early");

  a_debug_one_follows: assert property (enable_follows_p(7, debug_pull_en_n[1]))
    else $error("second debug enable did not follow write");
  a_tck_follows_write: assert property (enable_follows_p(6, test_pullup_en_n[0]))
    else $error("first test pullup did not follow write");
  a_tms_follows_write: assert property (enable_follows_p(6, test_pullup_en_n[2]))
    else $error("last test pullup did not follow write");
  a_hctl_zero_follows: assert property (enable_follows_p(4, host_ctrl_pull_en_n[0]))
    else $error("first host control enable did not follow write");
  a_hctl_last_follows: assert property (enable_follows_p(4, host_ctrl_pull_en_n[9]))
    else $error("last host control enable did not follow write");
  a_hdat_zero_follows: assert property (enable_follows_p(3, host_data_keeper_en_n[0]))
    else $error("first host data enable did not follow write");
  a_ectl_pullup_follows: assert property (enable_follows_p(2, ext_ctrl_keeper_en_n[3]))
    else $error("memory control pullup did not follow write");
  a_edat_zero_follows: assert property (enable_follows_p(1, ext_data_keeper_en_n[0]))
    else $error("first memory data enable did not follow write");
  a_eadr_zero_follows: assert property (enable_follows_p(0, ext_addr_keeper_en_n[0]))
    else $error("first memory address enable did not follow write");

  a_ready_always: assert property (@(posedge core_clk) disable iff (!resetn)
      pready == 1'b1)
    else $error("ready dropped");

  a_other_reads_zero: assert property (@(posedge core_clk) disable iff (!resetn)
      rd_other_s
      |-> prdata == 32'h00000000)
    else $error("unmapped read returned data");

  a_err_unmapped: assert property (@(posedge core_clk) disable iff (!resetn)
      access && !hits_ctrl(paddr)
      |-> pslverr)
    else $error("unmapped access without error");

  a_no_err_mapped: assert property (@(posedge core_clk) disable iff (!resetn)
      access && hits_ctrl(paddr)
      |-> !pslverr)
    else $error("mapped access flagged as error");

  a_idle_no_err: assert property (@(posedge core_clk) disable iff (!resetn)
      !access
      |-> !pslverr)
    else $error("error outside an access");

  a_idle_data_zero: assert property (@(posedge core_clk) disable iff (!resetn)
      !access
      |-> prdata == 32'h00000000)
    else $error("read data outside an access");

  a_masked_write_kept: assert property (@(posedge core_clk) disable iff (!resetn)
      wr_masked_s
      |=> $stable(state.ctrl))
    else $error("write with low strobe clear changed register");

  a_unmapped_write_kept: assert property (@(posedge core_clk) disable iff (!resetn)
      wr_other_s
      |=> $stable(state.ctrl))
    else $error("unmapped write changed register");

  a_write_low_byte: assert property (@(posedge core_clk) disable iff (!resetn)
      write_ctrl_s
      |=> state.ctrl == $past(pwdata[ctrl_bits-1:0]))
    else $error("register did not take low write byte");

  // no disable here: this one must look at the reset itself
  a_reset_clears_ctrl: assert property (@(posedge core_clk)
      !resetn ##1 !resetn
      |-> state.ctrl == '0)
    else $error("register not cleared in reset");

  a_reset_clears_pins: assert property (@(posedge core_clk)
      !resetn ##1 !resetn
      |-> debug_pull_en_n == '0 && test_pullup_en_n == '0 &&
      test_reset_pulldown_en_n == 1'b0 && watchdog_pull_en_n == 1'b0 &&
      host_ctrl_pull_en_n == '0 && host_data_keeper_en_n == '0 &&
      ext_ctrl_keeper_en_n == '0 && ext_data_keeper_en_n == '0 &&
      ext_addr_keeper_en_n == '0)
    else $error("pin enables not cleared in reset");

  a_debug_uniform: assert property (@(posedge core_clk) disable iff (!resetn)
      debug_pull_en_n == {debug_pin_count{debug_pull_en_n[0]}})
    else $error("debug group not uniform");

  a_test_uniform: assert property (@(posedge core_clk) disable iff (!resetn)
      {test_reset_pulldown_en_n, test_pullup_en_n} == {(test_pull_count+1){test_pullup_en_n[0]}})
    else $error("test group not uniform");

  a_hctl_uniform: assert property (@(posedge core_clk) disable iff (!resetn)
      host_ctrl_pull_en_n == {host_ctrl_count{host_ctrl_pull_en_n[host_ctrl_pd_index]}})
    else $error("host control group not uniform");

  a_hdat_uniform: assert property (@(posedge core_clk) disable iff (!resetn)
      host_data_keeper_en_n == {host_data_count{host_data_keeper_en_n[0]}})
    else $error("host data group not uniform");

  a_ectl_uniform: assert property (@(posedge core_clk) disable iff (!resetn)
      ext_ctrl_keeper_en_n == {ext_ctrl_count{ext_ctrl_keeper_en_n[0]}})
    else $error("memory control group not uniform");

  a_eadr_uniform: assert property (@(posedge core_clk) disable iff (!resetn)
      ext_addr_keeper_en_n == {ext_addr_count{ext_addr_keeper_en_n[0]}})
    else $error("memory address group not uniform");

  // pullup pins share the holder bit rather than a bit of their own
  a_ectl_pullups_match: assert property (@(posedge core_clk) disable iff (!resetn)
      (ext_ctrl_keeper_en_n & ext_ctrl_pullups) ==
      (ext_ctrl_pullups & {ext_ctrl_count{ext_ctrl_keeper_en_n[0]}}))
    else $error("memory control pullups split from holders");
endmodule

// >>> test/pin_pull_keeper_control_test.sv
// self-checking bench for the pin pull and keeper control register
`timescale 1ns/100ps
module pin_pull_keeper_control_test
  import pin_pull_pkg::*;
;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic        e;
  logic [7:0]  prev;
  logic [1:0]  debug_pull_en_n;
  logic [2:0]  test_pullup_en_n;
  logic        test_reset_pulldown_en_n, watchdog_pull_en_n;
  logic [9:0]  host_ctrl_pull_en_n;
  logic [7:0]  host_data_keeper_en_n;
  logic [15:0] ext_ctrl_keeper_en_n;
  logic [31:0] ext_data_keeper_en_n;
  logic [19:0] ext_addr_keeper_en_n;
  int          n_errors, n_checks;
  // write data beside the value it should read back; upper bits must be dropped
  logic [31:0] rows [10][2] = '{'{32'h1, 32'h1}, '{32'h2, 32'h2}, '{32'h4, 32'h4},
    '{32'h8, 32'h8}, '{32'h10, 32'h10}, '{32'h20, 32'h20}, '{32'h40, 32'h40},
    '{32'h80, 32'h80}, '{32'hFF, 32'hFF}, '{32'hFFFF_FF5A, 32'h5A}};

  pin_pull_keeper_control i_pin_pull_keeper_control (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_pull_en_n(debug_pull_en_n), .test_pullup_en_n(test_pullup_en_n),
    .test_reset_pulldown_en_n(test_reset_pulldown_en_n),
    .watchdog_pull_en_n(watchdog_pull_en_n), .host_ctrl_pull_en_n(host_ctrl_pull_en_n),
    .host_data_keeper_en_n(host_data_keeper_en_n),
    .ext_ctrl_keeper_en_n(ext_ctrl_keeper_en_n),
    .ext_data_keeper_en_n(ext_data_keeper_en_n),
    .ext_addr_keeper_en_n(ext_addr_keeper_en_n));

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  task summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // settles past the edge, compares every group, then realigns to the next edge
  task chk_en(input logic [7:0] v);
    #1;
    chk("debug", 32'({debug_pin_count{v[bit_debug_pins]}}), 32'(debug_pull_en_n));
    chk("test", 32'({4{v[bit_test_port]}}),
        32'({test_reset_pulldown_en_n, test_pullup_en_n}));
    chk("watchdog", 32'(v[bit_watchdog_pin]), 32'(watchdog_pull_en_n));
    chk("host ctrl", 32'({host_ctrl_count{v[bit_host_ctrl]}}), 32'(host_ctrl_pull_en_n));
    chk("host data", 32'({host_data_count{v[bit_host_data]}}), 32'(host_data_keeper_en_n));
    chk("ext ctrl", 32'({ext_ctrl_count{v[bit_ext_mem_ctrl]}}), 32'(ext_ctrl_keeper_en_n));
    chk("ext data", {ext_data_count{v[bit_ext_mem_data]}}, ext_data_keeper_en_n);
    chk("ext addr", 32'({ext_addr_count{v[bit_ext_mem_addr]}}), 32'(ext_addr_keeper_en_n));
    @(posedge core_clk);
  endtask

  // one apb transfer; entered and left just after a rising edge
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      summarize();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    n_errors = 0;
    n_checks = 0;
    prev = 8'h00;
    repeat (4) @(posedge core_clk);
    chk_en(8'h00);
    resetn <= 1'b1;
    apb(1'b0, pull_ctrl_offset, 32'h0, 4'h0);
    chk("reset read", 32'h0, r);
    for (int i = 0; i < 10; i++) begin
      chk_en(prev);
      apb(1'b1, pull_ctrl_offset, rows[i][0], 4'hF);
      chk("write err", 32'h0, 32'(e));
      chk_en(rows[i][1][7:0]);
      prev = rows[i][1][7:0];
      apb(1'b0, pull_ctrl_offset, 32'h0, 4'h0);
      chk("readback", rows[i][1], r);
    end
    // low strobe clear, then unmapped write and read
    apb(1'b1, pull_ctrl_offset, 32'h0, 4'hE);
    apb(1'b1, 16'h8804, 32'h0, 4'hF);
    chk("unmapped wr err", 32'h1, 32'(e));
    apb(1'b0, 16'h8804, 32'h0, 4'h0);
    chk("unmapped rd err", 32'h1, 32'(e));
    chk("unmapped rd", 32'h0, r);
    apb(1'b0, pull_ctrl_offset, 32'h0, 4'h0);
    chk("kept value", 32'h5A, r);
    chk_en(8'h5A);
    // second reset in mid-run clears everything at once
    #1 resetn = 1'b0;
    chk_en(8'h00);
    resetn <= 1'b1;
    apb(1'b0, pull_ctrl_offset, 32'h0, 4'h0);
    chk("reread", 32'h0, r);
    summarize();
  end
endmodule
